/* rtl/mtd_pkg.sv */
// Shared constants and types for the tape byte transfer and interrupt core.
package mtd_pkg;
    // Register indexes on the plain register port.
    localparam logic [2:0] MTD_REG_STATUS = 3'h0;
    localparam logic [2:0] MTD_REG_COMMAND = 3'h1;
    localparam logic [2:0] MTD_REG_COUNTER = 3'h2;
    localparam logic [2:0] MTD_REG_ADDRESS = 3'h3;
    localparam logic [2:0] MTD_REG_BUFFER = 3'h4;
    localparam logic [2:0] MTD_REG_READ_LINES = 3'h5;

    // Command register field positions.
    localparam int MTD_CMD_GO = 0;
    localparam int MTD_CMD_FUNC_LO = 1;
    localparam int MTD_CMD_NINE = 4;
    localparam int MTD_CMD_DENS_LO = 5;
    localparam int MTD_CMD_READY = 7;
    localparam int MTD_CMD_IE = 8;
    localparam int MTD_CMD_PAR_EVEN = 9;
    localparam int MTD_CMD_UNIT_LO = 10;
    localparam int MTD_CMD_XADDR_LO = 13;
    localparam int MTD_CMD_ERR = 15;

    // Character selector bit of the tape read lines register.
    localparam int MTD_RDL_SEL = 14;

    // Tape functions.
    localparam logic [2:0] MTD_FN_OFFLINE = 3'h0;
    localparam logic [2:0] MTD_FN_READ = 3'h1;
    localparam logic [2:0] MTD_FN_WRITE = 3'h2;
    localparam logic [2:0] MTD_FN_WEOF = 3'h3;
    localparam logic [2:0] MTD_FN_SPACE_FWD = 3'h4;
    localparam logic [2:0] MTD_FN_SPACE_REV = 3'h5;
    localparam logic [2:0] MTD_FN_WRITE_XGAP = 3'h6;
    localparam logic [2:0] MTD_FN_REWIND = 3'h7;

    // Density codes: 200, 556 and 800 bpi.
    localparam logic [1:0] MTD_DENS_200 = 2'h0;
    localparam logic [1:0] MTD_DENS_556 = 2'h1;
    localparam logic [1:0] MTD_DENS_800 = 2'h2;

    // End-of-file mark characters (octal 17 and octal 23).
    localparam logic [7:0] MTD_MARK_7CH = 8'h0F;
    localparam logic [7:0] MTD_MARK_9CH = 8'h13;

    // Reset values.
    localparam logic [15:0] MTD_RST_WORD = 16'h0000;
    localparam logic MTD_RST_READY = 1'b1;

    typedef enum logic [1:0] {
        MTD_IDLE = 2'b00,
        MTD_ACTIVE = 2'b01,
        MTD_DMA_WAIT = 2'b11,
        MTD_DMA_RUN = 2'b10
    } mtd_state_e;

    typedef struct packed {
        mtd_state_e st;
        logic [2:0] func;
        logic nine;
        logic [1:0] dens;
        logic ie;
        logic par_even;
        logic [2:0] unit;
        logic [1:0] xaddr;
        logic ready;
        logic err;
        logic [15:0] brc;
        logic [15:0] cma;
        logic [8:0] dbuf;
        logic rd_sel;
        logic cnt_done;
        logic bus_fail;
        logic dma_req;
        logic dma_write;
        logic irq;
        logic rew_pend;
        logic prev_rew;
        logic [15:0] rdata;
        logic tape_go;
        logic tape_stop;
        logic gap3;
        logic [7:0] wr_data;
        logic wr_valid;
    } mtd_regs_s;
endpackage

/* rtl/mtd_core.sv */
// Tape controller byte transfer, character assembly and interrupt core.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns

module mtd_core
    import mtd_pkg::*;
#(
    parameter int UNITS = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Memory transfer master.
    output logic dma_req,
    input wire logic dma_grant,
    input wire logic dma_done,
    input wire logic dma_fail,
    output logic dma_write,
    output logic [17:0] dma_addr,
    output logic [15:0] dma_wdata,
    input wire logic [15:0] dma_rdata,
    // Processor interrupt request.
    output logic irq,
    input wire logic irq_ack,
    // Transport strobes and read data.
    input wire logic read_strobe_pulse,
    input wire logic write_strobe_pulse,
    input wire logic [8:0] tape_char,
    input wire logic check_strobe,
    input wire logic check_is_lrc,
    input wire logic record_pulse,
    input wire logic tape_done,
    input wire logic tape_error,
    // Per-unit transport status.
    input wire logic [UNITS-1:0] unit_online,
    input wire logic [UNITS-1:0] unit_rewinding,
    input wire logic [UNITS-1:0] unit_bot,
    // Transport control.
    output logic tape_go,
    output logic tape_stop,
    output logic [2:0] tape_func,
    output logic [2:0] tape_unit,
    output logic tape_nine,
    output logic [1:0] tape_density,
    output logic tape_parity_even,
    output logic tape_gap3,
    output logic [7:0] tape_wr_data,
    output logic tape_wr_valid
);
    // The unit field is three bits, so at most eight units can be named.
    if (UNITS < 1 || UNITS > 8) begin : g_units_check
        $error("UNITS must lie between 1 and 8.");
    end

    mtd_regs_s r;
    mtd_regs_s next_r;

    // Pick one bit of a per-unit bus for the selected unit.
    function automatic logic pick(input logic [UNITS-1:0] v,
                                  input logic [2:0] u);
        pick = (32'(u) < UNITS) ? v[u] : 1'b0;
    endfunction

    function automatic logic is_write(input logic [2:0] f);
        is_write = (f == MTD_FN_WRITE) || (f == MTD_FN_WRITE_XGAP);
    endfunction

    logic sel_online;
    logic sel_rew;
    logic sel_bot;
    logic [15:0] cmd_word;
    logic [15:0] status_word;
    logic [15:0] brc_inc;
    logic [2:0] w_func;
    logic [2:0] w_unit;
    logic [1:0] w_dens;
    logic w_nine;
    logic xfer_ok;
    logic irq_set;

    always_comb begin
        sel_online = pick(unit_online, r.unit);
        sel_rew = pick(unit_rewinding, r.unit);
        sel_bot = pick(unit_bot, r.unit);
        // Go is write-only and reads back as zero.
        cmd_word = MTD_RST_WORD;
        cmd_word[MTD_CMD_FUNC_LO +: 3] = r.func;
        cmd_word[MTD_CMD_NINE] = r.nine;
        cmd_word[MTD_CMD_DENS_LO +: 2] = r.dens;
        cmd_word[MTD_CMD_READY] = r.ready;
        cmd_word[MTD_CMD_IE] = r.ie;
        cmd_word[MTD_CMD_PAR_EVEN] = r.par_even;
        cmd_word[MTD_CMD_UNIT_LO +: 3] = r.unit;
        cmd_word[MTD_CMD_XADDR_LO +: 2] = r.xaddr;
        cmd_word[MTD_CMD_ERR] = r.err;
        status_word = {10'h000, r.dma_req, r.cnt_done, r.bus_fail,
                       sel_bot, sel_rew, sel_online};
        brc_inc = r.brc + 16'h0001;
        w_func = reg_wdata[MTD_CMD_FUNC_LO +: 3];
        w_unit = reg_wdata[MTD_CMD_UNIT_LO +: 3];
        w_nine = reg_wdata[MTD_CMD_NINE];
        // Nine-channel tape is only ever written at 800 bpi.
        w_dens = w_nine ? MTD_DENS_800 :
                 reg_wdata[MTD_CMD_DENS_LO +: 2];
        // One character at a time, and none after terminal count.
        xfer_ok = (r.st == MTD_ACTIVE) && !r.cnt_done;
    end

    always_comb begin
        next_r = r;
        irq_set = 1'b0;
        next_r.tape_go = 1'b0;
        next_r.tape_stop = 1'b0;
        next_r.wr_valid = 1'b0;
        // Reset leaves this low like an idle unit, so no false edge follows.
        next_r.prev_rew = sel_rew;

        // Register reads answer one cycle later.
        if (reg_rd) begin
            case (reg_addr)
                MTD_REG_STATUS: next_r.rdata = status_word;
                MTD_REG_COMMAND: next_r.rdata = cmd_word;
                MTD_REG_COUNTER: next_r.rdata = r.brc;
                MTD_REG_ADDRESS: next_r.rdata = r.cma;
                MTD_REG_BUFFER: next_r.rdata = {7'h00, r.dbuf};
                MTD_REG_READ_LINES: next_r.rdata = {1'b0, r.rd_sel, 14'h0000};
                default: next_r.rdata = MTD_RST_WORD;
            endcase
        end

        // Rewind completion of the selected unit, before a new command.
        if (r.prev_rew && !sel_rew && r.rew_pend) begin
            next_r.rew_pend = 1'b0;
            irq_set = 1'b1;
        end

        // Transport status changes.
        if (tape_error && !r.err) begin
            next_r.err = 1'b1;
            irq_set = 1'b1;
        end
        if (r.st == MTD_ACTIVE && tape_done) begin
            next_r.st = MTD_IDLE;
            next_r.ready = 1'b1;
            irq_set = 1'b1;
        end

        // Read: latch a character and ask to store it.
        if (xfer_ok && read_strobe_pulse && r.func == MTD_FN_READ) begin
            if (r.nine) begin
                next_r.dbuf = tape_char;
            end else begin
                next_r.dbuf = {tape_char[8], 2'b00, tape_char[5:0]};
            end
            next_r.dma_write = 1'b1;
            next_r.dma_req = 1'b1;
            next_r.st = MTD_DMA_WAIT;
        end
        // Write: ask memory for the next byte.
        if (xfer_ok && write_strobe_pulse && is_write(r.func)) begin
            next_r.dma_write = 1'b0;
            next_r.dma_req = 1'b1;
            next_r.st = MTD_DMA_WAIT;
        end
        // End-of-record check character, read functions only.
        if (r.st == MTD_ACTIVE && check_strobe && r.func == MTD_FN_READ) begin
            if (r.nine && (check_is_lrc == r.rd_sel)) begin
                next_r.dbuf = tape_char;
            end else if (!r.nine && check_is_lrc && r.rd_sel) begin
                // With the selector clear the last data byte stays.
                next_r.dbuf = {tape_char[8], 2'b00, tape_char[5:0]};
            end
        end
        // Spacing counts records passed on the same counter.
        if (xfer_ok && record_pulse && (r.func == MTD_FN_SPACE_FWD ||
                                        r.func == MTD_FN_SPACE_REV)) begin
            next_r.brc = brc_inc;
            if (brc_inc == 16'h0000) begin
                next_r.cnt_done = 1'b1;
                next_r.tape_stop = 1'b1;
            end
        end

        if (r.st == MTD_DMA_WAIT && dma_grant) begin
            next_r.dma_req = 1'b0;
            next_r.st = MTD_DMA_RUN;
        end
        if (r.st == MTD_DMA_RUN && dma_fail) begin
            // Address is left pointing at the failed location.
            next_r.bus_fail = 1'b1;
            next_r.st = MTD_ACTIVE;
            next_r.tape_stop = 1'b1;
            if (!r.err) begin
                next_r.err = 1'b1;
                irq_set = 1'b1;
            end
        end else if (r.st == MTD_DMA_RUN && dma_done) begin
            if (!r.dma_write) begin
                // Pick the addressed half of the word read.
                next_r.dbuf[7:0] = r.cma[0] ? dma_rdata[15:8] :
                                   dma_rdata[7:0];
                next_r.wr_data = next_r.dbuf[7:0];
                next_r.wr_valid = 1'b1;
            end
            {next_r.xaddr, next_r.cma} = {r.xaddr, r.cma} + 18'h00001;
            next_r.brc = brc_inc;
            next_r.st = MTD_ACTIVE;
            if (brc_inc == 16'h0000) begin
                next_r.cnt_done = 1'b1;
            end
        end

        // Software register writes.
        if (reg_wr) begin
            case (reg_addr)
                MTD_REG_COMMAND: begin
                    if (!r.ready) begin
                        // Busy: the command is refused and flagged.
                        if (!r.err) begin
                            irq_set = 1'b1;
                        end
                        next_r.err = 1'b1;
                    end else begin
                        if (w_unit != r.unit) begin
                            next_r.rew_pend = 1'b0;
                        end
                        next_r.func = w_func;
                        next_r.nine = w_nine;
                        next_r.dens = w_dens;
                        next_r.ie = reg_wdata[MTD_CMD_IE];
                        next_r.par_even = reg_wdata[MTD_CMD_PAR_EVEN];
                        next_r.unit = w_unit;
                        next_r.xaddr = reg_wdata[MTD_CMD_XADDR_LO +: 2];
                        if (!reg_wdata[MTD_CMD_GO]) begin
                            irq_set = 1'b1;
                        end else begin
                            next_r.rew_pend = 1'b0;
                            // An error raised in this same cycle survives.
                            next_r.err = tape_error;
                            next_r.bus_fail = 1'b0;
                            next_r.cnt_done = 1'b0;
                            next_r.tape_go = 1'b1;
                            next_r.gap3 = 1'b0;
                            if (w_func == MTD_FN_REWIND) begin
                                // Ready stays set; one interrupt now and
                                // one more at the load point if not there.
                                irq_set = 1'b1;
                                next_r.rew_pend = !pick(unit_bot, w_unit);
                            end else begin
                                next_r.ready = 1'b0;
                                next_r.st = MTD_ACTIVE;
                            end
                            if (w_func == MTD_FN_WRITE_XGAP) begin
                                next_r.gap3 = 1'b1;
                            end
                            if (w_func == MTD_FN_WEOF) begin
                                // The functions are exclusive, so the end
                                // of file always gets its long gap.
                                next_r.gap3 = 1'b1;
                                next_r.wr_data = w_nine ? MTD_MARK_9CH :
                                                 MTD_MARK_7CH;
                                next_r.wr_valid = 1'b1;
                            end
                        end
                    end
                end
                MTD_REG_COUNTER: next_r.brc = reg_wdata;
                MTD_REG_ADDRESS: next_r.cma = reg_wdata;
                MTD_REG_BUFFER: next_r.dbuf = reg_wdata[8:0];
                MTD_REG_READ_LINES: next_r.rd_sel = reg_wdata[MTD_RDL_SEL];
                default: next_r.rd_sel = r.rd_sel;
            endcase
        end

        // A request that meets the acknowledge is kept, not lost.
        if (irq_ack) begin
            next_r.irq = 1'b0;
        end
        if (irq_set && next_r.ie) begin
            next_r.irq = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.st <= MTD_IDLE;
            r.ready <= MTD_RST_READY;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign dma_req = r.dma_req;
    assign dma_write = r.dma_write;
    assign dma_addr = {r.xaddr, r.cma};
    // Memory keeps the lane that address bit 0 names, so no steering here.
    assign dma_wdata = {r.dbuf[7:0], r.dbuf[7:0]};
    assign irq = r.irq;
    assign tape_go = r.tape_go;
    assign tape_stop = r.tape_stop;
    assign tape_func = r.func;
    assign tape_unit = r.unit;
    assign tape_nine = r.nine;
    assign tape_density = r.dens;
    assign tape_parity_even = r.par_even;
    assign tape_gap3 = r.gap3;
    assign tape_wr_data = r.wr_data;
    assign tape_wr_valid = r.wr_valid;
endmodule

/* tb/mtd_core_checker.sv */
// Port-level assertions for the tape transfer and interrupt core.
`timescale 1ns/1ns
module mtd_core_checker
    import mtd_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Memory transfer bus.
    input wire logic dma_req,
    input wire logic dma_grant,
    input wire logic dma_done,
    input wire logic dma_fail,
    input wire logic dma_write,
    input wire logic [17:0] dma_addr,
    input wire logic [15:0] dma_wdata,
    // Interrupt and transport.
    input wire logic irq,
    input wire logic irq_ack,
    input wire logic tape_nine,
    input wire logic [1:0] tape_density,
    input wire logic tape_wr_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_req_hold; dma_req && !dma_grant |=> dma_req; endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before grant");
    property p_req_drop; dma_req && dma_grant |=> !dma_req; endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request held after grant");
    property p_addr_step;
        dma_done |=> dma_addr == $past(dma_addr) + 18'h00001;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address did not step by one");
    property p_fail_keep; dma_fail |=> $stable(dma_addr); endproperty
    a_fail_keep: assert property (p_fail_keep)
        else $error("address moved after bus failure");
    property p_wr_char; dma_done && !dma_write |=> tape_wr_valid; endproperty
    a_wr_char: assert property (p_wr_char)
        else $error("no character sent after word read");
    property p_one_char; tape_wr_valid |=> !tape_wr_valid [*2]; endproperty
    a_one_char: assert property (p_one_char)
        else $error("character valid too long");
    // The offered byte stays put until the memory has taken it.
    property p_halves;
        dma_req && dma_write |=> $stable(dma_wdata) &&
            dma_wdata[15:8] == dma_wdata[7:0];
    endproperty
    a_halves: assert property (p_halves)
        else $error("byte not offered on both halves");
    property p_seven;
        dma_req && dma_write && !tape_nine |-> dma_wdata[7:6] == 2'h0;
    endproperty
    a_seven: assert property (p_seven)
        else $error("upper bits set on seven channel byte");
    property p_nine_dens; tape_nine |-> tape_density == MTD_DENS_800;
    endproperty
    a_nine_dens: assert property (p_nine_dens)
        else $error("nine channel not at highest density");
    property p_irq_hold; irq && !irq_ack |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without acknowledge");

    c_store: cover property (dma_done && dma_write);
    c_fetch: cover property (dma_done && !dma_write);
    c_fail: cover property (dma_fail);
    c_irq: cover property (irq && irq_ack);
endmodule

/* tb/mtd_mem_model.sv */
// Memory side of the transfer bus; answers promptly or slowly, may fail.
`timescale 1ns/1ns
module mtd_mem_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Transfer bus.
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [17:0] dma_addr,
    input wire logic [15:0] dma_wdata,
    output logic dma_grant,
    output logic dma_done,
    output logic dma_fail,
    output logic [15:0] dma_rdata,
    // Bench controls.
    input wire logic slow,
    input wire logic fail_next
);
    logic [7:0] mem [0:255];
    logic [1:0] ph;
    logic [2:0] cnt;
    logic [7:0] a;
    assign a = dma_addr[7:0];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hEE;
    end
    // Read data toggles outside the done cycle so a late sample is caught.
    always @(posedge clk) begin
        dma_grant <= 1'b0;
        dma_done <= 1'b0;
        dma_fail <= 1'b0;
        dma_rdata <= ~dma_rdata;
        if (srst) begin
            ph <= 2'h0;
            cnt <= 3'h0;
            dma_rdata <= 16'h5A5A;
        end else if (ph == 2'h0 && dma_req) begin
            if (cnt == (slow ? 3'h4 : 3'h0)) begin
                dma_grant <= 1'b1;
                ph <= 2'h1;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end else if (ph == 2'h1) begin
            ph <= 2'h2;
            cnt <= 3'h0;
            dma_fail <= fail_next;
            dma_done <= !fail_next;
            if (!fail_next && dma_write) begin
                mem[a] <= a[0] ? dma_wdata[15:8] : dma_wdata[7:0];
            end else if (!fail_next) begin
                dma_rdata <= {mem[{a[7:1], 1'b1}], mem[{a[7:1], 1'b0}]};
            end
        end else if (ph == 2'h2) begin
            ph <= 2'h0;
        end
    end
endmodule

/* tb/tb_mtd_core.sv */
// Self-checking bench for the tape transfer and interrupt core.
`timescale 1ns/1ns
module tb_mtd_core;
    import mtd_pkg::*;
    logic clk, srst, reg_wr, reg_rd, irq_ack, check_is_lrc, slow, fail_next;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, dma_wdata, dma_rdata, d;
    logic [8:0] tape_char;
    logic [7:0] bot, rew, tape_wr_data;
    logic [4:0] tp;
    logic dma_req, dma_grant, dma_done, dma_fail, dma_write, irq;
    logic tape_gap3, tape_wr_valid, tape_nine;
    logic tape_go, tape_stop, tape_parity_even, terr;
    logic [17:0] dma_addr;
    logic [2:0] tape_func, tape_unit;
    logic [1:0] tape_density;
    int mismatches, tests_run, gos;

    mtd_core #(.UNITS(8)) u_dut (.clk, .srst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .dma_req, .dma_grant, .dma_done,
        .dma_fail, .dma_write, .dma_addr, .dma_wdata, .dma_rdata, .irq,
        .irq_ack, .read_strobe_pulse(tp[0]), .write_strobe_pulse(tp[1]),
        .tape_char, .check_strobe(tp[2]), .check_is_lrc,
        .record_pulse(tp[3]), .tape_done(tp[4]), .tape_error(terr),
        .unit_online(8'hFF), .unit_rewinding(rew), .unit_bot(bot),
        .tape_go, .tape_stop, .tape_func, .tape_unit, .tape_nine,
        .tape_density, .tape_parity_even, .tape_gap3, .tape_wr_data,
        .tape_wr_valid);
    mtd_mem_model u_mem (.clk, .srst, .dma_req, .dma_write, .dma_addr,
        .dma_wdata, .dma_grant, .dma_done, .dma_fail, .dma_rdata, .slow,
        .fail_next);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Tally of transport starts, held against the accepted commands that carry go.
    always @(posedge clk) begin
        if (tape_go) begin
            gos++;
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // Every drive lands just after an edge, every sample sees settled values.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick();
        reg_wr <= 1'b0;
        tick();
    endtask
    task automatic rd(input logic [2:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        reg_rd <= 1'b0;
        d = reg_rdata;
        tick();
    endtask
    task automatic pul(input logic [4:0] m);
        tp <= m;
        tick();
        tp <= 5'h00;
        tick();
    endtask
    task automatic xfer(input logic [4:0] m, input logic [8:0] c);
        tape_char <= c;
        pul(m);
        for (int i = 0; i < 30 && !dma_done && !dma_fail; i++) tick();
        if (!(dma_done || dma_fail)) begin
            mismatches++;
            stop_test();
        end else begin
            tick();
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (4) tick();
        chk(irq, e);
        irq_ack <= 1'b1;
        tick();
        irq_ack <= 1'b0;
        tick();
    endtask
    task automatic op(input logic [2:0] f, input logic n, input logic [15:0] c,
                      input logic [15:0] a);
        wr(MTD_REG_COUNTER, c);
        wr(MTD_REG_ADDRESS, a);
        wr(MTD_REG_COMMAND, {7'h00, 1'b1, 3'h0, n, f, 1'b1});
    endtask
    // The selector picks which end-of-record character stays buffered.
    task automatic ends(input logic [7:0] e0, input logic [7:0] e1);
        for (int s = 0; s < 2; s++) begin
            wr(MTD_REG_READ_LINES, (s == 1) ? 16'h4000 : 16'h0000);
            tape_char <= 9'h05A;
            check_is_lrc <= 1'b0;
            pul(5'h04);
            tape_char <= 9'h133;
            check_is_lrc <= 1'b1;
            pul(5'h04);
            rd(MTD_REG_BUFFER);
            chk(d[7:0], (s == 1) ? e1 : e0);
        end
        pul(5'h10);
        irq_is(1'b1);
    endtask

    initial begin
        {srst, reg_wr, reg_rd, irq_ack, check_is_lrc, slow, fail_next} = 7'h40;
        {reg_addr, reg_wdata, tape_char, tp, bot, rew, terr} = '0;
        mismatches = 0;
        tests_run = 0;
        gos = 0;
        repeat (12) tick();
        srst <= 1'b0;
        rd(MTD_REG_COMMAND);
        chk(d, 16'h0080);
        rd(3'h6);
        chk(d, 16'h0000);
        op(MTD_FN_READ, 1'b1, 16'hFFFD, 16'h0010);
        xfer(5'h01, 9'h1A5);
        xfer(5'h01, 9'h033);
        slow <= 1'b1;
        xfer(5'h01, 9'h0C4);
        slow <= 1'b0;
        tape_char <= 9'h077;
        pul(5'h01);
        repeat (4) tick();
        chk(dma_req, 1'b0);
        chk(u_mem.mem[16], 8'hA5);
        chk(u_mem.mem[17], 8'h33);
        chk(u_mem.mem[18], 8'hC4);
        chk(u_mem.mem[19], 8'hEE);
        rd(MTD_REG_COUNTER);
        chk(d, 16'h0000);
        rd(MTD_REG_ADDRESS);
        chk(d, 16'h0013);
        ends(8'h5A, 8'h33);
        op(MTD_FN_READ, 1'b0, 16'hFFFF, 16'h0020);
        xfer(5'h01, 9'h1FF);
        chk(u_mem.mem[32], 8'h3F);
        ends(8'h3F, 8'h33);
        op(MTD_FN_WRITE, 1'b1, 16'hFFFE, 16'h0010);
        for (int i = 0; i < 2; i++) begin
            xfer(5'h02, 9'h000);
            chk(tape_wr_valid, 1'b1);
            chk(tape_wr_data, (i == 1) ? 8'h33 : 8'hA5);
        end
        wr(MTD_REG_COMMAND, 16'h0103);
        rd(MTD_REG_COMMAND);
        chk(d[15], 1'b1);
        irq_is(1'b1);
        pul(5'h10);
        irq_is(1'b1);
        op(MTD_FN_SPACE_FWD, 1'b1, 16'hFFFE, 16'h0000);
        pul(5'h08);
        tp <= 5'h08;
        tick();
        chk(tape_stop, 1'b1);
        tp <= 5'h00;
        tick();
        rd(MTD_REG_COUNTER);
        chk(d, 16'h0000);
        terr <= 1'b1;
        tick();
        terr <= 1'b0;
        irq_is(1'b1);
        pul(5'h10);
        irq_is(1'b1);
        fail_next <= 1'b1;
        op(MTD_FN_READ, 1'b1, 16'hFFFE, 16'h0040);
        xfer(5'h01, 9'h011);
        chk(tape_stop, 1'b1);
        fail_next <= 1'b0;
        rd(MTD_REG_ADDRESS);
        chk(d, 16'h0040);
        pul(5'h10);
        irq_is(1'b1);
        for (int i = 2; i >= 0; i--) begin
            op((i == 0) ? MTD_FN_WRITE : (i == 1) ? MTD_FN_WRITE_XGAP
               : MTD_FN_WEOF, 1'b1, 16'hFFFF, 16'h0000);
            chk(tape_gap3, i != 0);
            if (i == 2) begin
                chk(tape_wr_data, MTD_MARK_9CH);
            end
            pul(5'h10);
            irq_is(1'b1);
        end
        wr(MTD_REG_COMMAND, 16'h1320);
        chk(tape_parity_even, 1'b1);
        chk(tape_unit, 18'h4);
        chk(tape_density, MTD_DENS_556);
        irq_is(1'b1);
        wr(MTD_REG_COMMAND, 16'h0000);
        irq_is(1'b0);
        op(MTD_FN_REWIND, 1'b0, 16'h0000, 16'h0000);
        chk(tape_func, MTD_FN_REWIND);
        irq_is(1'b1);
        rew <= 8'h02;
        rd(MTD_REG_STATUS);
        chk(d[1], 1'b0);
        rew <= 8'h00;
        irq_is(1'b0);
        rew <= 8'h01;
        repeat (3) tick();
        rew <= 8'h00;
        irq_is(1'b1);
        bot <= 8'h01;
        op(MTD_FN_REWIND, 1'b0, 16'h0000, 16'h0000);
        irq_is(1'b1);
        rew <= 8'h01;
        repeat (3) tick();
        rew <= 8'h00;
        irq_is(1'b0);
        chk(gos, 18'h0A);
        stop_test();
    end
endmodule

bind mtd_core mtd_core_checker u_chk (.clk(clk), .srst(srst),
    .dma_req(dma_req), .dma_grant(dma_grant), .dma_done(dma_done),
    .dma_fail(dma_fail), .dma_write(dma_write), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .irq(irq), .irq_ack(irq_ack),
    .tape_nine(tape_nine), .tape_density(tape_density),
    .tape_wr_valid(tape_wr_valid));
